// >>> logic/mmpf_top.sv
/*
 * Performance monitor of the mesh_memory_bridge: four wide counters and
 * box-level opcode/class/address filters, reached through config space.
 * Assumes packet and event inputs come from logic on i_clk, and that
 * config reads and writes are single-cycle strobes.
 */
// Notes on behaviour
// - Four independent 48-bit counters, each able to select any event.
// - Each counter can add up to five per cycle, so increments are wide.
// - Mask/match filters pick packets heading to DRAM or to the mesh.
// - Packets passing the filters form a filter_hit_event to count.
// - Inbound and outbound criteria are held together; each applies to its own direction.
// - Bits 27:22 hold the outbound opcode mask, 21:16 its compare.
// - Bits 15:12 hold the inbound class mask, 11:8 its compare.
// - Class codes are demand 0000, response 0010, bypass 1010, etc.
// - Bits 7:4 hold the inbound opcode mask, 3:0 its compare.
// - Low address mask and compare hold address bits 31:0.
// - High address mask and compare hold address bits 45:32 at 13:0 of a 14:0 field.
`timescale 1ns/1ps
module mmpf_top
   import mmpf_pkg::*;
#(
   parameter int NUM_EV = 64
) (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_cfg_wr,
   input wire logic i_cfg_rd,
   input wire logic [11:0] i_cfg_addr,
   input wire logic [31:0] i_cfg_wdata,
   output logic [31:0] o_cfg_rdata,
   output logic o_cfg_rd_valid,
   input wire logic [NUM_EV-1:0][INC_W-1:0] i_event_inc,
   input wire mmpf_in_pkt_s i_in_pkt,
   input wire mmpf_out_pkt_s i_out_pkt,
   output logic o_filter_hit_in,
   output logic o_filter_hit_out
);

   ////////////////////////////////////////////////////////////////////////
   // Filter registers

   mmpf_opc_filter_s opc_r;
   logic [31:0] addr_match_lo_r;
   logic [31:0] addr_mask_lo_r;
   logic [ADDR_HI_FIELD_W-1:0] addr_match_hi_r;
   logic [ADDR_HI_FIELD_W-1:0] addr_mask_hi_r;
   mmpf_ctl_s ctl_r [NUM_CTR];

   wire wr_opc = i_cfg_wr && (i_cfg_addr == OFS_OPCODE_FILTER);
   wire wr_match_lo = i_cfg_wr && (i_cfg_addr == OFS_ADDR_MATCH_LO);
   wire wr_match_hi = i_cfg_wr && (i_cfg_addr == OFS_ADDR_MATCH_HI);
   wire wr_mask_lo = i_cfg_wr && (i_cfg_addr == OFS_ADDR_MASK_LO);
   wire wr_mask_hi = i_cfg_wr && (i_cfg_addr == OFS_ADDR_MASK_HI);

   // Field extraction; reserved 31:28 is dropped, never stored
   mmpf_opc_filter_s opc_wr;
   assign opc_wr.out_opc_mask =
      i_cfg_wdata[OUT_OPC_MASK_LSB +: 6];
   assign opc_wr.out_opc_cmp =
      i_cfg_wdata[OUT_OPC_CMP_LSB +: 6];
   assign opc_wr.class_select_mask =
      i_cfg_wdata[IN_CLS_MASK_LSB +: 4];
   assign opc_wr.class_compare =
      i_cfg_wdata[IN_CLS_CMP_LSB +: 4];
   assign opc_wr.in_opc_mask =
      i_cfg_wdata[IN_OPC_MASK_LSB +: 4];
   assign opc_wr.in_opc_cmp =
      i_cfg_wdata[IN_OPC_CMP_LSB +: 4];

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         opc_r <= '0;
         addr_match_lo_r <= RESET_WORD;
         addr_mask_lo_r <= RESET_WORD;
         addr_match_hi_r <= '0;
         addr_mask_hi_r <= '0;
      end else begin
         if (wr_opc) opc_r <= opc_wr;
         if (wr_match_lo) addr_match_lo_r <= i_cfg_wdata;
         if (wr_mask_lo) addr_mask_lo_r <= i_cfg_wdata;
         if (wr_match_hi) begin
            addr_match_hi_r <= i_cfg_wdata[ADDR_HI_FIELD_W-1:0];
         end
         if (wr_mask_hi) begin
            addr_mask_hi_r <= i_cfg_wdata[ADDR_HI_FIELD_W-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Packet matching

   // Top bit of the high field is beyond address bit 45 and never compared
   wire [ADDR_W-1:0] addr_mask = {addr_mask_hi_r[ADDR_W-33:0],
      addr_mask_lo_r};
   wire [ADDR_W-1:0] addr_match = {addr_match_hi_r[ADDR_W-33:0],
      addr_match_lo_r};

   wire in_addr_ok = ((i_in_pkt.addr ^ addr_match) & addr_mask) == '0;
   wire out_addr_ok = ((i_out_pkt.addr ^ addr_match) & addr_mask) == '0;

   // Class codes of CLS_* are compared as software programs them
   wire in_cls_ok = ((i_in_pkt.class_compare ^ opc_r.class_compare)
      & opc_r.class_select_mask) == '0;
   wire in_opc_ok = ((i_in_pkt.opcode ^ opc_r.in_opc_cmp)
      & opc_r.in_opc_mask) == '0;
   wire out_opc_ok = ((i_out_pkt.opcode ^ opc_r.out_opc_cmp)
      & opc_r.out_opc_mask) == '0;

   // Both directions judged every cycle, independently
   wire in_hit = i_in_pkt.valid && in_cls_ok && in_opc_ok
      && in_addr_ok;
   wire out_hit = i_out_pkt.valid && out_opc_ok
      && out_addr_ok;

   // One hit per direction per cycle, so the event adds 0..2
   wire [INC_W-1:0] hit_inc = INC_W'(in_hit) + INC_W'(out_hit);

   logic hit_in_r;
   logic hit_out_r;
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         hit_in_r <= 1'b0;
         hit_out_r <= 1'b0;
      end else begin
         hit_in_r <= in_hit;
         hit_out_r <= out_hit;
      end
   end
   assign o_filter_hit_in = hit_in_r;
   assign o_filter_hit_out = hit_out_r;

   ////////////////////////////////////////////////////////////////////////
   // Counters

   logic [CTR_W-1:0] count [NUM_CTR];

   genvar g;
   generate
      for (g = 0; g < NUM_CTR; g++) begin : g_ctr
         localparam logic [11:0] OFS_LO = OFS_CTR_BASE + 12'(8 * g);
         localparam logic [11:0] OFS_HI = OFS_CTR_BASE + 12'(8 * g + 4);
         localparam logic [11:0] OFS_CTL = OFS_CTL_BASE + 12'(4 * g);

         wire wr_ctl = i_cfg_wr && (i_cfg_addr == OFS_CTL);
         wire wr_lo = i_cfg_wr && (i_cfg_addr == OFS_LO);
         wire wr_hi = i_cfg_wr && (i_cfg_addr == OFS_HI);
         wire clr = wr_ctl && i_cfg_wdata[CTL_CLR_BIT];
         wire [7:0] sel = ctl_r[g].sel;
         wire sel_in_range = 32'(sel) < NUM_EV;

         // Any event or the filter hit may be chosen
         wire [INC_W-1:0] inc = (sel == FILTER_HIT_CODE) ? hit_inc :
            sel_in_range ? i_event_inc[sel] :
            '0;

         always_ff @(posedge i_clk) begin
            if (i_reset) begin
               ctl_r[g] <= '0;
            end else if (wr_ctl) begin
               ctl_r[g].en <= i_cfg_wdata[CTL_EN_BIT];
               ctl_r[g].sel <= i_cfg_wdata[CTL_SEL_LSB +: 8];
            end
         end

         // Multi-bit increment up to five per cycle
         mmpf_counter #(
            .W(CTR_W)
         ) u_ctr (
            .i_clk(i_clk),
            .i_reset(i_reset),
            .i_en(ctl_r[g].en),
            .i_inc(inc),
            .i_clr(clr),
            .i_wr_lo(wr_lo),
            .i_wr_hi(wr_hi),
            .i_wdata(i_cfg_wdata),
            .o_count(count[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Read path

   logic [31:0] rd_word;
   logic [31:0] rdata_r;
   logic rd_valid_r;

   // Reserved and unmapped bits read back as zero
   always_comb begin
      rd_word = 32'h0000_0000;
      unique case (i_cfg_addr)
         OFS_OPCODE_FILTER: begin
            rd_word[OUT_OPC_MASK_LSB +: 6] = opc_r.out_opc_mask;
            rd_word[OUT_OPC_CMP_LSB +: 6] = opc_r.out_opc_cmp;
            rd_word[IN_CLS_MASK_LSB +: 4] = opc_r.class_select_mask;
            rd_word[IN_CLS_CMP_LSB +: 4] = opc_r.class_compare;
            rd_word[IN_OPC_MASK_LSB +: 4] = opc_r.in_opc_mask;
            rd_word[IN_OPC_CMP_LSB +: 4] = opc_r.in_opc_cmp;
         end
         OFS_ADDR_MATCH_LO: rd_word = addr_match_lo_r;
         OFS_ADDR_MASK_LO: rd_word = addr_mask_lo_r;
         OFS_ADDR_MATCH_HI: rd_word[ADDR_HI_FIELD_W-1:0] = addr_match_hi_r;
         OFS_ADDR_MASK_HI: rd_word[ADDR_HI_FIELD_W-1:0] = addr_mask_hi_r;
         default: begin
            for (int n = 0; n < NUM_CTR; n++) begin
               if (i_cfg_addr == OFS_CTR_BASE + 12'(8 * n)) begin
                  rd_word = count[n][31:0];
               end
               if (i_cfg_addr == OFS_CTR_BASE + 12'(8 * n + 4)) begin
                  rd_word[CTR_W-33:0] = count[n][CTR_W-1:32];
               end
               if (i_cfg_addr == OFS_CTL_BASE + 12'(4 * n)) begin
                  rd_word[CTL_EN_BIT] = ctl_r[n].en;
                  rd_word[CTL_SEL_LSB +: 8] = ctl_r[n].sel;
               end
            end
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         rdata_r <= RESET_WORD;
         rd_valid_r <= 1'b0;
      end else begin
         rd_valid_r <= i_cfg_rd;
         if (i_cfg_rd) rdata_r <= rd_word;
      end
   end

   assign o_cfg_rdata = rdata_r;
   assign o_cfg_rd_valid = rd_valid_r;

endmodule : mmpf_top

// >>> shared/mmpf_pkg.sv
/*
 * Constants and types for the mesh/memory bridge monitor filter.
 * Assumes a 12-bit configuration-space offset and 32-bit data words.
 */
package mmpf_pkg;

   localparam int CTR_W = 48;
   localparam int INC_W = 3;
   localparam int ADDR_W = 46;
   localparam int NUM_CTR = 4;

   // Box-level filter offsets
   localparam logic [11:0] OFS_ADDR_MATCH_LO = 12'h268;
   localparam logic [11:0] OFS_ADDR_MATCH_HI = 12'h26C;
   localparam logic [11:0] OFS_ADDR_MASK_LO = 12'h270;
   localparam logic [11:0] OFS_ADDR_MASK_HI = 12'h274;
   localparam logic [11:0] OFS_OPCODE_FILTER = 12'h278;
   // Counter words: low at base + 8n, high at base + 8n + 4
   localparam logic [11:0] OFS_CTR_BASE = 12'h2A0;
   // Counter control at base + 4n
   localparam logic [11:0] OFS_CTL_BASE = 12'h2C0;

   // Opcode filter fields
   localparam int OUT_OPC_MASK_LSB = 22;
   localparam int OUT_OPC_CMP_LSB = 16;
   localparam int IN_CLS_MASK_LSB = 12;
   localparam int IN_CLS_CMP_LSB = 8;
   localparam int IN_OPC_MASK_LSB = 4;
   localparam int IN_OPC_CMP_LSB = 0;
   localparam int ADDR_HI_FIELD_W = 15;

   // Counter control fields
   localparam int CTL_EN_BIT = 22;
   localparam int CTL_CLR_BIT = 17;
   localparam int CTL_SEL_LSB = 0;
   localparam logic [7:0] FILTER_HIT_CODE = 8'hFF;

   // Inbound message classes
   localparam logic [3:0] CLS_DEMAND = 4'h0;
   localparam logic [3:0] CLS_RESPONSE = 4'h2;
   localparam logic [3:0] CLS_NC_BYPASS = 4'hA;
   localparam logic [3:0] CLS_NC_STANDARD = 4'hB;
   localparam logic [3:0] CLS_WRITEBACK = 4'hC;

   localparam logic [31:0] RESET_WORD = 32'h0000_0000;

   typedef struct packed {
      logic valid;
      logic [3:0] class_compare;
      logic [3:0] opcode;
      logic [ADDR_W-1:0] addr;
   } mmpf_in_pkt_s;

   typedef struct packed {
      logic valid;
      logic [5:0] opcode;
      logic [ADDR_W-1:0] addr;
   } mmpf_out_pkt_s;

   typedef struct packed {
      logic [5:0] out_opc_mask;
      logic [5:0] out_opc_cmp;
      logic [3:0] class_select_mask;
      logic [3:0] class_compare;
      logic [3:0] in_opc_mask;
      logic [3:0] in_opc_cmp;
   } mmpf_opc_filter_s;

   typedef struct packed {
      logic en;
      logic [7:0] sel;
   } mmpf_ctl_s;

endpackage : mmpf_pkg

// >>> logic/mmpf_counter.sv
/*
 * One wide event counter with software load and clear.
 * Assumes the increment is already selected and at most five.
 */
`timescale 1ns/1ps
module mmpf_counter
   import mmpf_pkg::*;
#(
   parameter int W = CTR_W
) (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_en,
   input wire logic [INC_W-1:0] i_inc,
   input wire logic i_clr,
   input wire logic i_wr_lo,
   input wire logic i_wr_hi,
   input wire logic [31:0] i_wdata,
   output logic [W-1:0] o_count
);

   logic [W-1:0] count_r;
   logic [W-1:0] count_nxt;

   // Software access wins over counting in the same cycle
   always_comb begin
      count_nxt = count_r;
      if (i_clr) begin
         count_nxt = '0;
      end else if (i_wr_lo) begin
         count_nxt = {count_r[W-1:32], i_wdata};
      end else if (i_wr_hi) begin
         count_nxt = {i_wdata[W-33:0], count_r[31:0]};
      end else if (i_en) begin
         // Natural wrap at the top of the counter
         count_nxt = count_r + W'(i_inc);
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         count_r <= '0;
      end else begin
         count_r <= count_nxt;
      end
   end

   assign o_count = count_r;

endmodule : mmpf_counter

// >>> bench/mmpf_top_sva.sv
/*
 * Port checker for mmpf_top: config strobes, read data and hit outputs.
 * Assumes the bind below reaches every mmpf_top instance.
 */
`timescale 1ns/1ps
module mmpf_top_sva
   import mmpf_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_cfg_wr,
   input wire logic i_cfg_rd,
   input wire logic [11:0] i_cfg_addr,
   input wire logic [31:0] i_cfg_wdata,
   input wire logic [31:0] o_cfg_rdata,
   input wire logic o_cfg_rd_valid,
   input wire mmpf_in_pkt_s i_in_pkt,
   input wire mmpf_out_pkt_s i_out_pkt,
   input wire logic o_filter_hit_in,
   input wire logic o_filter_hit_out
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_reset);
   ////////////////////////////////////////////////////////////////////////
   AST_RD_ANSWER: assert property (i_cfg_rd |=> o_cfg_rd_valid)
      else $error("read strobe not answered");
   AST_RD_QUIET: assert property (!i_cfg_rd |=> !o_cfg_rd_valid)
      else $error("read valid without strobe");
   AST_RD_HOLD: assert property (!i_cfg_rd |=> $stable(o_cfg_rdata))
      else $error("read data moved without a read");
   AST_OPC_RSV: assert property (i_cfg_rd && i_cfg_addr == OFS_OPCODE_FILTER
      |=> o_cfg_rdata[31:28] == 4'h0)
      else $error("opcode filter top bits not zero");
   AST_HI_RSV: assert property (i_cfg_rd && i_cfg_addr == OFS_ADDR_MASK_HI
      |=> o_cfg_rdata[31:15] == 17'h0)
      else $error("high mask top bits not zero");
   AST_MASK_LO_RB: assert property ((i_cfg_wr && i_cfg_addr == OFS_ADDR_MASK_LO
      ##1 !i_cfg_wr ##1 i_cfg_rd && i_cfg_addr == OFS_ADDR_MASK_LO)
      |=> o_cfg_rdata == $past(i_cfg_wdata, 3))
      else $error("low mask readback wrong");
   AST_HIT_IN: assert property (!i_in_pkt.valid |=> !o_filter_hit_in)
      else $error("inbound hit without packet");
   AST_HIT_OUT: assert property (!i_out_pkt.valid |=> !o_filter_hit_out)
      else $error("outbound hit without packet");
   COV_BOTH: cover property (o_filter_hit_in && o_filter_hit_out);
   COV_IN_ONLY: cover property (o_filter_hit_in && !o_filter_hit_out);
   COV_RD: cover property (i_cfg_wr ##2 i_cfg_rd);
endmodule : mmpf_top_sva
////////////////////////////////////////////////////////////////////////////
bind mmpf_top mmpf_top_sva u_sva (.i_clk(i_clk), .i_reset(i_reset),
   .i_cfg_wr(i_cfg_wr), .i_cfg_rd(i_cfg_rd), .i_cfg_addr(i_cfg_addr),
   .i_cfg_wdata(i_cfg_wdata), .o_cfg_rdata(o_cfg_rdata),
   .o_cfg_rd_valid(o_cfg_rd_valid), .i_in_pkt(i_in_pkt),
   .i_out_pkt(i_out_pkt), .o_filter_hit_in(o_filter_hit_in),
   .o_filter_hit_out(o_filter_hit_out));

// >>> bench/tb_top.sv
/*
 * Self-checking bench for mmpf_top: registers, filters, counters.
 * Assumes the checker binds itself; no partner model.
 */
`timescale 1ns/1ps
module tb_top;
   import mmpf_pkg::*;
   logic i_clk = 0, i_reset = 1, i_cfg_wr = 0, i_cfg_rd = 0;
   logic [11:0] i_cfg_addr = '0;
   logic [31:0] i_cfg_wdata = '0, o_cfg_rdata;
   logic o_cfg_rd_valid, o_filter_hit_in, o_filter_hit_out;
   logic [7:0][INC_W-1:0] i_event_inc = '0;
   mmpf_in_pkt_s i_in_pkt = '0;
   mmpf_out_pkt_s i_out_pkt = '0;
   int fail_count = 0, samples_checked = 0, cyc = 0, hits = 0;
   logic [11:0] ofs [5] = '{OFS_ADDR_MATCH_LO, OFS_ADDR_MATCH_HI,
      OFS_ADDR_MASK_LO, OFS_ADDR_MASK_HI, OFS_OPCODE_FILTER};
   logic [31:0] rmask [5] = '{32'hFFFFFFFF, 32'h00007FFF, 32'hFFFFFFFF,
      32'h00007FFF, 32'h0FFFFFFF};
   logic [3:0] cls [5] = '{CLS_DEMAND, CLS_RESPONSE, CLS_NC_BYPASS,
      CLS_NC_STANDARD, CLS_WRITEBACK};
   mmpf_top #(.NUM_EV(8)) u_dut (.i_clk(i_clk), .i_reset(i_reset),
      .i_cfg_wr(i_cfg_wr), .i_cfg_rd(i_cfg_rd), .i_cfg_addr(i_cfg_addr),
      .i_cfg_wdata(i_cfg_wdata), .o_cfg_rdata(o_cfg_rdata),
      .o_cfg_rd_valid(o_cfg_rd_valid), .i_event_inc(i_event_inc),
      .i_in_pkt(i_in_pkt), .i_out_pkt(i_out_pkt),
      .o_filter_hit_in(o_filter_hit_in), .o_filter_hit_out(o_filter_hit_out));
   always #5 i_clk = ~i_clk;
   ////////////////////////////////////////////////////////////////////////
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : wrap_up
   task automatic chk32(string n, logic [31:0] e, logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask : chk32
   task automatic chk1(string n, logic e, logic g);
      samples_checked++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED %s expected %b seen %b", n, e, g);
      end
   endtask : chk1
   // Strobe dropped for a cycle so back-to-back calls never collide
   task automatic wr(logic [11:0] a, logic [31:0] d);
      @(posedge i_clk);
      i_cfg_wr <= 1'b1;
      i_cfg_addr <= a;
      i_cfg_wdata <= d;
      @(posedge i_clk);
      i_cfg_wr <= 1'b0;
   endtask : wr
   task automatic rd(logic [11:0] a, logic [31:0] e);
      @(posedge i_clk);
      i_cfg_rd <= 1'b1;
      i_cfg_addr <= a;
      @(posedge i_clk);
      i_cfg_rd <= 1'b0;
      #1;
      chk1("rd_valid", 1'b1, o_cfg_rd_valid);
      chk32("rdata", e, o_cfg_rdata);
   endtask : rd
   task automatic pkt(logic [3:0] c, logic [5:0] oo, logic [45:0] a,
      logic ei, logic eo);
      @(posedge i_clk);
      i_in_pkt <= {1'b1, c, 4'h9, a};
      i_out_pkt <= {1'b1, oo, a};
      @(posedge i_clk);
      i_in_pkt.valid <= 1'b0;
      i_out_pkt.valid <= 1'b0;
      #1;
      chk1("hit_in", ei, o_filter_hit_in);
      chk1("hit_out", eo, o_filter_hit_out);
      hits += ei + eo;
   endtask : pkt
   ////////////////////////////////////////////////////////////////////////
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 3000) begin
         fail_count++;
         wrap_up();
      end
   end
   initial begin
      repeat (6) @(posedge i_clk);
      i_reset <= 1'b0;
      for (int i = 0; i < 5; i++) rd(ofs[i], 32'h0);
      for (int i = 0; i < 5; i++) begin
         // Reserved bits are written as zero, never as ones
         wr(ofs[i], rmask[i]);
         rd(ofs[i], rmask[i]);
      end
      rd(12'h000, 32'h0);
      wr(OFS_ADDR_MASK_LO, 32'h0000FF00);
      wr(OFS_ADDR_MATCH_LO, 32'h00001200);
      wr(OFS_ADDR_MASK_HI, 32'h00000001);
      wr(OFS_ADDR_MATCH_HI, 32'h00000001);
      wr(OFS_CTL_BASE + 12'h4, 32'h004000FF);
      for (int i = 0; i < 5; i++) begin
         wr(OFS_OPCODE_FILTER,
            {4'h0, 6'h3F, 6'h15, 4'hF, cls[i], 8'hF9});
         pkt(cls[i], 6'h15, 46'h1_0000_1234, 1, 1);
         pkt(cls[(i + 1) % 5], 6'h14, 46'h1_0000_1234, 0, 0);
      end
      pkt(cls[4], 6'h14, 46'h1_0000_1234, 1, 0);
      pkt(cls[4], 6'h15, 46'h0_0000_1234, 0, 0);
      pkt(cls[4], 6'h15, 46'h1_0000_1334, 0, 0);
      // Inbound opcode compare no longer 9: only outbound may hit
      wr(OFS_OPCODE_FILTER,
         {4'h0, 6'h3F, 6'h15, 4'hF, cls[4], 8'hF8});
      rd(OFS_OPCODE_FILTER,
         {4'h0, 6'h3F, 6'h15, 4'hF, cls[4], 8'hF8});
      pkt(cls[4], 6'h15, 46'h1_0000_1234, 0, 1);
      rd(OFS_CTR_BASE + 12'h8, 32'(hits));
      wr(OFS_CTR_BASE + 12'h10, 32'hFFFFFFFF);
      wr(OFS_CTR_BASE + 12'h14, 32'h0000FFFF);
      wr(OFS_CTL_BASE, 32'h00400000);
      wr(OFS_CTL_BASE + 12'h8, 32'h00400001);
      wr(OFS_CTL_BASE + 12'hC, 32'h00400007);
      @(posedge i_clk);
      i_event_inc[0] <= 3'd5;
      i_event_inc[1] <= 3'd1;
      repeat (3) @(posedge i_clk);
      i_event_inc <= '0;
      rd(OFS_CTR_BASE, 32'd15);
      rd(OFS_CTR_BASE + 12'h10, 32'd2);
      rd(OFS_CTR_BASE + 12'h14, 32'h0);
      rd(OFS_CTR_BASE + 12'h18, 32'h0);
      wr(OFS_CTL_BASE, 32'h00420000);
      rd(OFS_CTR_BASE, 32'h0);
      wrap_up();
   end
endmodule : tb_top
